// File: dv/uee_host.sv
// uart host model that drives the memory's serial port through its pins
module uee_host (
  input wire logic clk,
  output logic chip_select_pin,
  output logic shift_clock_pin,
  output logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // link driver
  // ------------------------------------------------------------------
  logic link_bad = 1'b0; // sticky: output enable or dummy bit seen wrong
  // a released output line floats back to its idle high level
  wire logic rx_line = serial_out_oe ? serial_out_pin : 1'b1;

  // line rests low; the link clock stands still outside frames
  initial begin
    chip_select_pin = 1'b0;
    shift_clock_pin = 1'b0;
    serial_in_pin = 1'b0;
  end

  // one framed bit per 48 ns link clock
  task automatic xfer(input logic [7:0] c, input logic [7:0] d1,
                      input logic [7:0] d2, input int n, input logic rdop,
                      output logic [15:0] rd);
    logic [7:0] fb [3];
    fb = '{c, d1, d2};
    rd = 16'h0000;
    // pins move just after an edge; half a link bit is six clocks
    @(posedge clk);
    // select from the modem line opens the instruction
    chip_select_pin <= 1'b1;
    repeat (25) @(posedge clk);
    // frames follow back to back, no idle between them
    for (int k = 0; k < n; k++) begin
      // start bit reads as one, stop bit as zero
      if (rdop && k >= 10) serial_in_pin <= 1'b0;
      else if (k % 10 == 0) serial_in_pin <= 1'b1;
      else if (k % 10 == 9) serial_in_pin <= 1'b0;
      else serial_in_pin <= fb[k / 10][k % 10 - 1];
      repeat (6) @(posedge clk);
      if (serial_out_oe !== (rdop && k >= 9)) link_bad = 1'b1;
      if (rdop && k == 9 && rx_line !== 1'b0) link_bad = 1'b1;
      // raw bits kept, stop positions not judged
      if (rdop && k >= 10) rd = {rd[14:0], rx_line};
      shift_clock_pin <= 1'b1;
      repeat (6) @(posedge clk);
      shift_clock_pin <= 1'b0;
    end
    // select drops before any further rising clock
    chip_select_pin <= 1'b0;
    // programming wait, shortened since the core does not time it
    repeat (50) @(posedge clk);
  endtask : xfer
endmodule : uee_host

// File: dv/uee_top_tb.sv
// self-checking bench for the uart-framed serial memory core
module uee_top_tb
  import uee_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // harness
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs, sck, si, so, oe, pp;
  logic [15:0] rd;
  int bad_count = 0;
  int tests_run = 0;
  // rows: address nibble, second byte, third byte, word read back
  logic [35:0] rows [4] = '{36'h0a5f3695c, 36'hf3c0f4f1f, 36'h5ff007fd0,
                            36'ha01966016};

  always #2 clk = ~clk;

  uee_top uee_top_inst (.clk(clk), .rst(rst), .chip_select_pin(cs),
    .shift_clock_pin(sck), .serial_in_pin(si), .serial_out_pin(so),
    .serial_out_oe(oe), .prog_pending(pp));

  uee_host uee_host_inst (.clk(clk), .chip_select_pin(cs),
    .shift_clock_pin(sck),
    .serial_in_pin(si), .serial_out_pin(so), .serial_out_oe(oe));

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // uart byte: first opcode bit in bit 0, address msb in bit 4
  function automatic logic [7:0] cmd(input logic [1:0] op,
                                     input logic [1:0] ext,
                                     input logic [3:0] a);
    return {a[0], a[1], a[2], a[3], ext[0], ext[1], op[0], op[1]};
  endfunction : cmd

  // stop, start, byte two, stop, start, low nibble of byte three
  function automatic logic [15:0] word(input logic [7:0] b,
                                       input logic [7:0] c);
    return {2'b01, b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7],
            2'b01, c[0], c[1], c[2], c[3]};
  endfunction : word

  // erase or write, then look at the pending flag while select is low
  task automatic prog(input logic [7:0] c, input logic [7:0] d1,
                      input logic [7:0] d2, input int n, input logic ep);
    uee_host_inst.xfer(c, d1, d2, n, 1'b0, rd);
    check("prog_pending low select", {15'h0, pp}, {15'h0, ep});
  endtask : prog

  // the select rise of a read also commits any pending programming
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    uee_host_inst.xfer(cmd(UEE_OP_READ, 2'h0, a), 8'h00, 8'h00, 26, 1'b1,
                       rd);
    check("read word", rd, exp);
    check("prog_pending after read", {15'h0, pp}, 16'h0000);
  endtask : rdchk

  // hang guard, well beyond the 32 us the sequence needs
  initial begin
    #300us;
    bad_count++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("outputs after reset", {13'h0, so, oe, pp}, 16'h0000);
    rdchk(4'h3, UEE_ERASED);
    // ordinary rows: erase, write, read back
    foreach (rows[i]) begin
      prog(cmd(UEE_OP_ERASE, 2'h0, rows[i][35:32]), 8'h00, 8'h00, 10,
           1'b1);
      prog(cmd(UEE_OP_WRITE, 2'h0, rows[i][35:32]), rows[i][31:24],
           rows[i][23:16], 30, 1'b1);
      rdchk(rows[i][35:32], rows[i][15:0]);
    end
    // erase of a written word brings back all ones
    prog(cmd(UEE_OP_ERASE, 2'h0, 4'h0), 8'h00, 8'h00, 10, 1'b1);
    rdchk(4'h0, UEE_ERASED);
    // select dropped after six bits must not program
    prog(cmd(UEE_OP_WRITE, 2'h0, 4'hf), 8'h00, 8'h00, 6, 1'b0);
    rdchk(4'hf, word(8'h3c, 8'h0f));
    // enable is a no-op; then whole-array erase and write
    prog(cmd(UEE_OP_EXT, 2'h3, 4'h0), 8'h00, 8'h00, 10, 1'b0);
    prog(cmd(UEE_OP_EXT, UEE_EXT_ERAL, 4'h0), 8'h00, 8'h00, 10,
         1'b1);
    rdchk(4'h5, UEE_ERASED);
    prog(cmd(UEE_OP_EXT, UEE_EXT_WRAL, 4'h0), 8'h3c, 8'ha5, 30,
         1'b1);
    rdchk(4'h7, word(8'h3c, 8'ha5));
    rdchk(4'h0, word(8'h3c, 8'ha5));
    // a second reset mid-run empties the array again
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("outputs after reset", {13'h0, so, oe, pp}, 16'h0000);
    rdchk(4'h7, UEE_ERASED);
    check("link flags", {15'h0, uee_host_inst.link_bad}, 16'h0000);
    end_of_test();
  end
endmodule : uee_top_tb

// File: hw/uee_sync.sv
// three-stage input synchroniser with agreement filter
module uee_sync
  import uee_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------------------------------
  // capture chain
  // ----------------------------------------------------------------
  // first stage feeds only the second, so metastability stays contained
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once the second and third stage agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      sync_out <= s3_r;
    end
  end

endmodule : uee_sync

// File: hw/uee_top.sv
// serial eeprom core: 16 words of 16 bits behind a uart-driven port
// Overview of operation
// RL1: serial output stays disabled while command, address or data shift in.
// RL2: host drops select after the last write bit; extra bits are ignored.
// RL3: programming happens only when select rises after a low pulse.
// RL4: uart transmit drives serial input; serial output feeds uart receive.
// RL5: chip select comes from a uart modem control output.
// RL6: shift clock is the uart 1x bit clock, one bit per clock.
// RL7: host sets 1x clock, 8 data, 1 stop, no parity, select high.
// RL8: host waits until its transmitter has drained before a new transfer.
// RL9: erase precedes write; opcode ending in two ones erases, cells go ones.
// RL10: host drops select after erase frame and waits 30 ms; the host model waits 50 clocks.
// RL11: host queues command byte then two data bytes back to back.
// RL12: only 16 bits stored per write; trailing four bits are discarded.
// RL13: first start bit is the memory start bit; framing bits get stored.
// RL14: host reads by sending one opcode-plus-address byte.
// RL15: host takes the returned word as two received bytes.
// RL16: shift in and out on rising clock; read data opens with zero.
// RL17: host ignores framing errors caused by memory output bits.
module uee_top
  import uee_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_pin,
  input wire logic shift_clock_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic prog_pending
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_f, sk_f, si_f;
  logic sk_d_r;
  logic sk_rise;

  uee_sync u_sync_cs (.clk(clk), .rst(rst), .async_in(chip_select_pin),
    .sync_out(cs_f));
  uee_sync u_sync_sk (.clk(clk), .rst(rst), .async_in(shift_clock_pin),
    .sync_out(sk_f));
  uee_sync u_sync_si (.clk(clk), .rst(rst), .async_in(serial_in_pin),
    .sync_out(si_f));

  // edge found on the filtered clock, never on a raw stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sk_d_r <= 1'b0;
    end else begin
      sk_d_r <= sk_f;
    end
  end

  assign sk_rise = sk_f & ~sk_d_r;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  uee_state_t state_r;
  logic [4:0] cnt_r;
  logic [7:0] cmd_r;
  logic [7:0] cmd_full;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [15:0] mem [UEE_WORDS];
  logic [1:0] op_hi;
  logic [1:0] op_ext;
  logic [3:0] cmd_addr;
  logic [1:0] nxt_hi;
  logic [3:0] nxt_addr;
  logic cmd_last;
  logic commit;

  // byte as it stands after the bit being sampled now
  assign cmd_full = {cmd_r[6:0], si_f};
  assign nxt_hi = cmd_full[7:6];
  assign nxt_addr = cmd_full[3:0];
  assign op_hi = cmd_r[7:6];
  assign op_ext = cmd_r[5:4];
  assign cmd_addr = cmd_r[3:0];
  assign cmd_last = (state_r == UEE_ST_CMD) && cs_f && sk_rise &&
                    (cnt_r == UEE_CNT_CMD_LAST);
  // RL3: commit on select
  assign commit = (state_r == UEE_ST_PROG) && cs_f;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one select window runs one instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= UEE_ST_IDLE;
      cnt_r <= UEE_CNT_ZERO;
    end else begin
      case (state_r)
        UEE_ST_IDLE: begin
          if (cs_f) begin
            state_r <= UEE_ST_WAIT;
          end
        end
        UEE_ST_WAIT: begin
          if (!cs_f) begin
            state_r <= UEE_ST_IDLE;
          // RL13: start bit detect
          end else if (sk_rise && si_f) begin
            state_r <= UEE_ST_CMD;
            cnt_r <= UEE_CNT_ZERO;
          end
        end
        UEE_ST_CMD: begin
          if (!cs_f) begin
            state_r <= UEE_ST_IDLE;
          end else if (cmd_last) begin
            cnt_r <= UEE_CNT_ZERO;
            case (nxt_hi)
              UEE_OP_READ: state_r <= UEE_ST_READ;
              UEE_OP_WRITE: state_r <= UEE_ST_DATA;
              // RL9: erase opcode
              UEE_OP_ERASE: state_r <= UEE_ST_ARMED;
              // extended codes: write-all, erase-all, else a no-op
              default: state_r <=
                  (cmd_full[5:4] == UEE_EXT_WRAL) ? UEE_ST_DATA :
                  (cmd_full[5:4] == UEE_EXT_ERAL) ? UEE_ST_ARMED : UEE_ST_DONE;
            endcase
          end else if (sk_rise) begin
            cnt_r <= cnt_r + UEE_CNT_ONE;
          end
        end
        UEE_ST_DATA: begin
          if (!cs_f) begin
            state_r <= UEE_ST_IDLE;
          end else if (sk_rise) begin
            cnt_r <= cnt_r + UEE_CNT_ONE;
            if (cnt_r == UEE_CNT_DATA_LAST) begin
              state_r <= UEE_ST_ARMED;
            end
          end
        end
        UEE_ST_ARMED: begin
          // RL12: trailing bits ignored
          if (!cs_f) begin
            state_r <= UEE_ST_PROG;
          end
        end
        UEE_ST_READ: begin
          if (!cs_f) begin
            state_r <= UEE_ST_IDLE;
          end else if (sk_rise && cnt_r != UEE_CNT_RD_DONE) begin
            cnt_r <= cnt_r + UEE_CNT_ONE;
          end
        end
        UEE_ST_DONE: begin
          if (!cs_f) begin
            state_r <= UEE_ST_IDLE;
          end
        end
        UEE_ST_PROG: begin
          // RL3: select pulse ends
          if (cs_f) begin
            state_r <= UEE_ST_WAIT;
          end
        end
        default: begin
          state_r <= UEE_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input shifters
  // ----------------------------------------------------------------
  // RL16: shift on rising
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= 8'h00;
    end else if (state_r == UEE_ST_CMD && cs_f && sk_rise) begin
      cmd_r <= cmd_full;
    end
  end

  // RL13: framing bits stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdata_r <= 16'h0000;
    end else if (state_r == UEE_ST_DATA && cs_f && sk_rise) begin
      wdata_r <= {wdata_r[14:0], si_f};
    end
  end

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  // reset loads the erased pattern; a real part would keep contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < UEE_WORDS; i++) begin
        mem[i] <= UEE_ERASED;
      end
    end else if (commit) begin
      case (op_hi)
        UEE_OP_WRITE: mem[cmd_addr] <= wdata_r;
        // RL9: erase to ones
        UEE_OP_ERASE: mem[cmd_addr] <= UEE_ERASED;
        UEE_OP_EXT: begin
          for (int i = 0; i < UEE_WORDS; i++) begin
            mem[i] <= (op_ext == UEE_EXT_WRAL) ? wdata_r : UEE_ERASED;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // RL16: dummy zero first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (cmd_last && nxt_hi == UEE_OP_READ) begin
      rdata_r <= mem[nxt_addr];
    end else if (state_r == UEE_ST_READ && cs_f && sk_rise) begin
      rdata_r <= {rdata_r[14:0], 1'b0};
    end
  end

  // RL1: output off during input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_out_oe <= 1'b0;
      serial_out_pin <= 1'b0;
    end else if (!cs_f) begin
      serial_out_oe <= 1'b0;
      serial_out_pin <= 1'b0;
    end else if (cmd_last && nxt_hi == UEE_OP_READ) begin
      serial_out_oe <= 1'b1;
      serial_out_pin <= 1'b0;
    end else if (state_r == UEE_ST_READ && sk_rise) begin
      // past the word the pin echoes the input line
      serial_out_pin <= (cnt_r == UEE_CNT_RD_DONE) ? si_f : rdata_r[15];
    end
  end

  // programming flag shown while select is low after an erase or write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_pending <= 1'b0;
    end else begin
      prog_pending <= (state_r == UEE_ST_ARMED && !cs_f) ||
                      (state_r == UEE_ST_PROG && !cs_f);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_arm_drop;
    (state_r == UEE_ST_ARMED) && !cs_f;
  endsequence
  sequence s_read_enter;
    cmd_last && (nxt_hi == UEE_OP_READ);
  endsequence
  AST_OUT_QUIET: assert property ( // RL1
    @(posedge clk) disable iff (rst)
    (state_r == UEE_ST_WAIT || state_r == UEE_ST_CMD ||
     state_r == UEE_ST_DATA) |-> !serial_out_oe)
    else $error("serial output enabled while shifting in");
  AST_PROG_ON_PULSE: assert property ( // RL3
    @(posedge clk) disable iff (rst)
    s_arm_drop |=> (state_r == UEE_ST_PROG) && prog_pending &&
                   $stable(mem[cmd_addr]))
    else $error("programming not held until select pulse");
  AST_ERASE_ONES: assert property ( // RL9
    @(posedge clk) disable iff (rst)
    (commit && op_hi == UEE_OP_ERASE) |=>
      (mem[$past(cmd_addr)] == UEE_ERASED) && state_r == UEE_ST_WAIT)
    else $error("erased word not all ones");
  AST_WORD_16: assert property ( // RL12
    @(posedge clk) disable iff (rst)
    (state_r == UEE_ST_ARMED && cs_f && sk_rise) |=>
      (state_r == UEE_ST_ARMED) && $stable(wdata_r))
    else $error("bits past the word altered write data");
  AST_START_BIT: assert property ( // RL13
    @(posedge clk) disable iff (rst)
    (state_r == UEE_ST_WAIT && cs_f && sk_rise && si_f) |=>
      (state_r == UEE_ST_CMD) && (cnt_r == UEE_CNT_ZERO))
    else $error("start bit not taken");
  AST_DUMMY_ZERO: assert property ( // RL16
    @(posedge clk) disable iff (rst)
    s_read_enter |=> serial_out_oe && !serial_out_pin &&
                     (rdata_r == mem[$past(nxt_addr)]))
    else $error("read did not open with dummy zero");

endmodule : uee_top

// File: inc/uee_pkg.sv
// constants for the uart-framed serial eeprom access block
package uee_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int unsigned UEE_ADDR_W = 4;
  localparam int unsigned UEE_WORDS = 16;
  localparam int unsigned UEE_WORD_W = 16;
  localparam int unsigned UEE_CMD_W = 8;
  localparam int unsigned UEE_CNT_W = 5;

  // erased cells read back as all ones
  localparam logic [15:0] UEE_ERASED = 16'hffff;

  // ----------------------------------------------------------------
  // bit counts within one instruction
  // ----------------------------------------------------------------
  localparam logic [4:0] UEE_CNT_ZERO = 5'h00;
  localparam logic [4:0] UEE_CNT_ONE = 5'h01;
  localparam logic [4:0] UEE_CNT_CMD_LAST = 5'h07;
  localparam logic [4:0] UEE_CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0] UEE_CNT_RD_DONE = 5'h10;

  // ----------------------------------------------------------------
  // opcodes: two major bits, then two extension bits
  // ----------------------------------------------------------------
  localparam logic [1:0] UEE_OP_EXT = 2'h0;
  localparam logic [1:0] UEE_OP_WRITE = 2'h1;
  localparam logic [1:0] UEE_OP_READ = 2'h2;
  localparam logic [1:0] UEE_OP_ERASE = 2'h3;
  localparam logic [1:0] UEE_EXT_WRAL = 2'h1;
  localparam logic [1:0] UEE_EXT_ERAL = 2'h2;

  // ----------------------------------------------------------------
  // instruction sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UEE_ST_IDLE = 3'h0,   // select low
    UEE_ST_WAIT = 3'h1,   // selected, waiting for the start bit
    UEE_ST_CMD = 3'h2,    // opcode and address shifting in
    UEE_ST_DATA = 3'h3,   // write data shifting in
    UEE_ST_ARMED = 3'h4,  // erase or write fully received
    UEE_ST_READ = 3'h5,   // read data shifting out
    UEE_ST_DONE = 3'h6,   // instruction over, wait for deselect
    UEE_ST_PROG = 3'h7    // select low, programming pending
  } uee_state_t;

endpackage : uee_pkg
